// [verilog/qsl_top.v]
// Four asynchronous serial line units behind one AXI4-Lite register slave.
// Assumes rxd inputs already synchronous to aclk; one clock, synchronous reset.
`timescale 1ns/10ps
`include "qsl_map.vh"

// Summary of operation
// - Frames are one start bit, eight data bits, one high stop bit, no parity.
// - Transmit and receive holding buffers are eight bits; upper bits hold no data.
// - Transmit ready clears on buffer write, sets when the byte has fully shifted out.
// - With transmit enable set, transmit request rises together with transmit ready.
// - Receiver assembles bits, moves byte to buffer, sets full; buffer read clears it.
// - With receive enable set, receive request rises whenever full flag sets.
// - Overrun sets when byte moves in unread; clears on clean move or reset.
// - Framing fault sets on bad stop bit; next good byte or reset clears it.
// - Receive buffer bit 15 is the OR of overrun and framing fault.
// - Receiver active sets on start bit detection, clears when the byte moves to buffer or at reset.
// - Break flag reflects input low for eleven bit periods; clears when input high.
// - Loopback bit feeds receiver from own serial output, ignoring external input.
// - Transmit break bit holds output low; software, reset or bus reset clear it.
// - Both interrupt enables are writable; cleared by software, reset or bus reset.
// - Reset clears transmit buffer, received data, ready, full and fault flags.
// - All eight interrupt sources request at priority level four.
// - Arbiter serves receive before transmit; unit 0 first, unit 3 last.
module qsl_top #(
  parameter UNITS    = 4,
  parameter ADDR_W   = 8,
  parameter BAUD_DIV = `QSL_BAUD_DIV_RST
) (
  input  wire               aclk,
  input  wire               aresetn,
  input  wire               bus_init,
  input  wire [ADDR_W-1:0]  s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [ADDR_W-1:0]  s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  input  wire [UNITS-1:0]   rxd,
  output wire [UNITS-1:0]   txd,
  output wire [UNITS-1:0]   rx_int_request,
  output wire [UNITS-1:0]   tx_int_request,
  output wire               irq,
  output wire [2:0]         irq_priority,
  output reg                irq_grant_valid,
  output reg  [2:0]         irq_grant_id
);

  localparam RX_IDLE  = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA  = 2'h2;
  localparam RX_STOP  = 2'h3;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function mapped;
    input [ADDR_W-1:0] a;
    begin
      mapped = (a[ADDR_W-1:2] <= `QSL_LAST_WORD);
    end
  endfunction

  // Lowest index wins: receive sources sit below transmit sources
  function [3:0] pick;
    input [7:0] r;
    integer k;
    begin
      pick = 4'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (r[k]) begin
          pick = {1'b1, k[2:0]};
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  reg                aw_ok_r;
  reg  [ADDR_W-1:0]  aw_addr_r;
  reg                w_ok_r;
  reg  [31:0]        w_data_r;
  reg  [3:0]         w_strb_r;
  wire               wr_go;
  wire [3:0]         wr_unit_sel;

  assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok_r && !s_axi_bvalid;
  assign wr_go         = aw_ok_r && w_ok_r && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r      <= 1'b0;
      aw_addr_r    <= {ADDR_W{1'b0}};
      w_ok_r       <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `QSL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_r   <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_r   <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ok_r      <= 1'b0;
        w_ok_r       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? `QSL_RESP_OKAY : `QSL_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte lane 0 carries every control field of the line units
  wire wr_lo = wr_go && w_strb_r[0];

  // ----------------------------------------------------------------
  // Shared configuration and interrupt registers
  // ----------------------------------------------------------------
  reg  [15:0]  baud_div_r;
  reg  [7:0]   irq_stat_r;
  reg  [7:0]   irq_mask_r;
  wire [7:0]   irq_event;
  wire [7:0]   irq_enab;
  wire [7:0]   irq_req;
  wire [19:0]  brk_len;
  wire [3:0]   grant_nxt;

  assign brk_len = {4'h0, baud_div_r} * `QSL_BREK_BITS;

  always @(posedge aclk) begin
    if (!aresetn) begin
      baud_div_r <= BAUD_DIV[15:0];
      irq_mask_r <= 8'h00;
      irq_stat_r <= 8'h00;
    end else begin
      if (wr_go && aw_addr_r == `QSL_ADDR_BAUD) begin
        if (w_strb_r[0]) begin
          baud_div_r[7:0] <= w_data_r[7:0];
        end
        if (w_strb_r[1]) begin
          baud_div_r[15:8] <= w_data_r[15:8];
        end
      end
      if (wr_lo && aw_addr_r == `QSL_ADDR_IRQ_MASK) begin
        irq_mask_r <= w_data_r[7:0];
      end
      // Set wins over a same-cycle write-one clear
      if (wr_lo && aw_addr_r == `QSL_ADDR_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~w_data_r[7:0]) | irq_event;
      end else begin
        irq_stat_r <= irq_stat_r | irq_event;
      end
    end
  end

  assign irq_req      = irq_stat_r & irq_mask_r & irq_enab;
  assign irq          = |irq_req;
  assign irq_priority = `QSL_IRQ_PRIORITY;
  assign grant_nxt    = pick(irq_req);

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_grant_valid <= 1'b0;
      irq_grant_id    <= 3'h0;
    end else begin
      irq_grant_valid <= grant_nxt[3];
      irq_grant_id    <= grant_nxt[2:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  wire [16*UNITS-1:0] rxcs_q;
  wire [16*UNITS-1:0] rxbuf_q;
  wire [16*UNITS-1:0] txcs_q;
  wire [16*UNITS-1:0] txbuf_q;
  wire                rd_go;
  wire [1:0]          rd_unit;
  wire [1:0]          rd_reg;
  reg  [15:0]         rd_mux;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign rd_unit       = s_axi_araddr[5:4];
  assign rd_reg        = s_axi_araddr[3:2];

  always @* begin
    rd_mux = 16'h0000;
    if (s_axi_araddr[ADDR_W-1:6] == {(ADDR_W-6){1'b0}}) begin
      if (rd_reg == `QSL_OFF_RXCS) begin
        rd_mux = rxcs_q[16*rd_unit +: 16];
      end else if (rd_reg == `QSL_OFF_RXBUF) begin
        rd_mux = rxbuf_q[16*rd_unit +: 16];
      end else if (rd_reg == `QSL_OFF_TXCS) begin
        rd_mux = txcs_q[16*rd_unit +: 16];
      end else begin
        rd_mux = txbuf_q[16*rd_unit +: 16];
      end
    end else if (s_axi_araddr == `QSL_ADDR_BAUD) begin
      rd_mux = baud_div_r;
    end else if (s_axi_araddr == `QSL_ADDR_IRQ_STAT) begin
      rd_mux = {8'h00, irq_stat_r};
    end else if (s_axi_araddr == `QSL_ADDR_IRQ_MASK) begin
      rd_mux = {8'h00, irq_mask_r};
    end else if (s_axi_araddr == `QSL_ADDR_IRQ_GRANT) begin
      rd_mux = {12'h000, irq_grant_valid, irq_grant_id};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `QSL_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_mux};
      s_axi_rresp  <= mapped(s_axi_araddr) ? `QSL_RESP_OKAY : `QSL_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Line units
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < UNITS; g = g + 1) begin : unit
      wire        in_unit  = (aw_addr_r[ADDR_W-1:6] == {(ADDR_W-6){1'b0}}) &&
                             (aw_addr_r[5:4] == g);
      wire        wr_rxcs  = wr_lo && in_unit && aw_addr_r[3:2] == `QSL_OFF_RXCS;
      wire        wr_txcs  = wr_lo && in_unit && aw_addr_r[3:2] == `QSL_OFF_TXCS;
      wire        wr_txbuf = wr_lo && in_unit && aw_addr_r[3:2] == `QSL_OFF_TXBUF;
      wire        rd_rxbuf = rd_go && s_axi_araddr[ADDR_W-1:6] == {(ADDR_W-6){1'b0}} &&
                             rd_unit == g && rd_reg == `QSL_OFF_RXBUF;
      reg         rx_ie_r;
      reg         tx_ie_r;
      reg         loop_r;
      reg         tx_brk_r;
      reg         boot_r;
      reg         tx_ready_r;
      reg         tx_pend_r;
      reg  [7:0]  tx_hold_r;
      reg  [9:0]  tx_sh_r;
      reg  [3:0]  tx_bits_r;
      reg  [15:0] tx_cnt_r;
      reg         txd_r;
      reg  [1:0]  rx_st_r;
      reg  [15:0] rx_cnt_r;
      reg  [2:0]  rx_bits_r;
      reg  [7:0]  rx_sh_r;
      reg  [7:0]  rx_buf_r;
      reg         rx_full_r;
      reg         rx_ovr_r;
      reg         rx_frm_r;
      reg         rx_act_r;
      reg  [19:0] brk_cnt_r;
      reg         rx_brk_r;
      reg         tx_ready_d_r;
      reg         rx_move_r;
      wire        rx_in;
      wire        tx_tick;
      wire        rx_tick;
      wire        rx_move;

      assign rx_in   = loop_r ? txd_r : rxd[g];
      assign tx_tick = (tx_cnt_r == baud_div_r - 16'h0001);
      assign rx_tick = (rx_cnt_r == baud_div_r - 16'h0001);
      assign rx_move = (rx_st_r == RX_STOP) && rx_tick;

      // Control bits; bus_init clears enables and break like a bus reset
      always @(posedge aclk) begin
        if (!aresetn || bus_init) begin
          rx_ie_r  <= 1'b0;
          tx_ie_r  <= 1'b0;
          tx_brk_r <= 1'b0;
          loop_r   <= 1'b0;
        end else begin
          if (wr_rxcs) begin
            rx_ie_r <= w_data_r[`QSL_RXCS_IE];
          end
          if (wr_txcs) begin
            tx_ie_r  <= w_data_r[`QSL_TXCS_IE];
            loop_r   <= w_data_r[`QSL_TXCS_LOOP];
            tx_brk_r <= w_data_r[`QSL_TXCS_BRK];
          end
        end
      end

      // Transmitter: start, 8 data LSB first, stop
      always @(posedge aclk) begin
        if (!aresetn) begin
          boot_r     <= 1'b0;
          tx_ready_r <= 1'b0;
          tx_pend_r  <= 1'b0;
          tx_hold_r  <= 8'h00;
          tx_sh_r    <= 10'h3ff;
          tx_bits_r  <= 4'h0;
          tx_cnt_r   <= 16'h0000;
          txd_r      <= 1'b1;
        end else begin
          boot_r <= 1'b1;
          txd_r  <= tx_brk_r ? 1'b0 : tx_sh_r[0];
          if (tx_bits_r != 4'h0) begin
            if (tx_tick) begin
              tx_cnt_r  <= 16'h0000;
              tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
              tx_bits_r <= tx_bits_r - 4'h1;
            end else begin
              tx_cnt_r <= tx_cnt_r + 16'h0001;
            end
          end else if (tx_pend_r) begin
            tx_sh_r   <= {1'b1, tx_hold_r, 1'b0};
            tx_bits_r <= `QSL_FRAME_BITS;
            tx_cnt_r  <= 16'h0000;
            tx_pend_r <= 1'b0;
          end
          // Idle transmitter reports ready once after reset
          if (!boot_r || (tx_bits_r == 4'h1 && tx_tick && !tx_pend_r)) begin
            tx_ready_r <= 1'b1;
          end
          // A write late in the stop bit still wins: the new byte is pending
          if (wr_txbuf) begin
            tx_hold_r  <= w_data_r[7:0];
            tx_pend_r  <= 1'b1;
            tx_ready_r <= 1'b0;
          end
        end
      end

      // Receiver: qualify start at half bit, then sample every bit centre
      always @(posedge aclk) begin
        if (!aresetn) begin
          rx_st_r   <= RX_IDLE;
          rx_cnt_r  <= 16'h0000;
          rx_bits_r <= 3'h0;
          rx_sh_r   <= 8'h00;
          rx_buf_r  <= 8'h00;
          rx_full_r <= 1'b0;
          rx_ovr_r  <= 1'b0;
          rx_frm_r  <= 1'b0;
          rx_act_r  <= 1'b0;
        end else begin
          case (rx_st_r)
            RX_IDLE: begin
              rx_cnt_r <= 16'h0000;
              if (!rx_in) begin
                rx_st_r <= RX_START;
              end
            end
            RX_START: begin
              if (rx_cnt_r == {1'b0, baud_div_r[15:1]}) begin
                rx_cnt_r  <= 16'h0000;
                rx_bits_r <= 3'h0;
                if (!rx_in) begin
                  rx_st_r  <= RX_DATA;
                  rx_act_r <= 1'b1;
                end else begin
                  rx_st_r <= RX_IDLE;
                end
              end else begin
                rx_cnt_r <= rx_cnt_r + 16'h0001;
              end
            end
            RX_DATA: begin
              if (rx_tick) begin
                rx_cnt_r <= 16'h0000;
                rx_sh_r  <= {rx_in, rx_sh_r[7:1]};
                if (rx_bits_r == `QSL_DATA_LAST) begin
                  rx_st_r <= RX_STOP;
                end else begin
                  rx_bits_r <= rx_bits_r + 3'h1;
                end
              end else begin
                rx_cnt_r <= rx_cnt_r + 16'h0001;
              end
            end
            default: begin
              if (rx_tick) begin
                rx_st_r  <= RX_IDLE;
                rx_buf_r <= rx_sh_r;
                rx_ovr_r <= rx_full_r;
                rx_frm_r <= !rx_in;
                rx_act_r <= 1'b0;
              end else begin
                rx_cnt_r <= rx_cnt_r + 16'h0001;
              end
            end
          endcase
          // Arrival beats a same-cycle buffer read
          if (rx_move) begin
            rx_full_r <= 1'b1;
          end else if (rd_rxbuf) begin
            rx_full_r <= 1'b0;
          end
        end
      end

      // Break detect: low for eleven bit periods
      always @(posedge aclk) begin
        if (!aresetn || rx_in) begin
          brk_cnt_r <= 20'h00000;
          rx_brk_r  <= 1'b0;
        end else if (brk_cnt_r == brk_len) begin
          rx_brk_r <= 1'b1;
        end else begin
          brk_cnt_r <= brk_cnt_r + 20'h00001;
        end
      end

      always @(posedge aclk) begin
        if (!aresetn) begin
          tx_ready_d_r <= 1'b0;
          rx_move_r    <= 1'b0;
        end else begin
          tx_ready_d_r <= tx_ready_r;
          rx_move_r    <= rx_move;
        end
      end

      assign irq_event[g]       = rx_move_r;
      assign irq_event[4+g]     = tx_ready_r && !tx_ready_d_r;
      assign irq_enab[g]        = rx_ie_r;
      assign irq_enab[4+g]      = tx_ie_r;
      assign rx_int_request[g]  = rx_ie_r && rx_full_r;
      assign tx_int_request[g]  = tx_ie_r && tx_ready_r;
      assign txd[g]             = txd_r;
      assign rxcs_q[16*g +: 16] = {4'h0, rx_act_r, 3'h0, rx_full_r, rx_ie_r, 6'h00};
      assign rxbuf_q[16*g +: 16] = {rx_ovr_r | rx_frm_r, rx_ovr_r, rx_frm_r, 1'b0,
                                    rx_brk_r, 3'h0, rx_buf_r};
      assign txcs_q[16*g +: 16] = {8'h00, tx_ready_r, tx_ie_r, 3'h0, loop_r, 1'b0, tx_brk_r};
      assign txbuf_q[16*g +: 16] = {8'h00, tx_hold_r};
    end
  endgenerate

endmodule

// [verilog/qsl_map.vh]
// Register map, field positions, reset values and timing for the quad serial line unit.
// Assumes AXI4-Lite byte addressing with one aligned 32-bit word per register.
`ifndef QSL_MAP_VH
`define QSL_MAP_VH

// ----------------------------------------------------------------
// Byte addresses and word offsets
// ----------------------------------------------------------------
`define QSL_UNIT_STRIDE     8'h10
`define QSL_OFF_RXCS        2'h0
`define QSL_OFF_RXBUF       2'h1
`define QSL_OFF_TXCS        2'h2
`define QSL_OFF_TXBUF       2'h3
`define QSL_ADDR_BAUD       8'h40
`define QSL_ADDR_IRQ_STAT   8'h44
`define QSL_ADDR_IRQ_MASK   8'h48
`define QSL_ADDR_IRQ_GRANT  8'h4c
`define QSL_LAST_WORD       6'h13

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define QSL_RXCS_ACTIVE     11
`define QSL_RXCS_FULL       7
`define QSL_RXCS_IE         6
`define QSL_RXB_ERR         15
`define QSL_RXB_OVR         14
`define QSL_RXB_FRM         13
`define QSL_RXB_BRK         11
`define QSL_TXCS_READY      7
`define QSL_TXCS_IE         6
`define QSL_TXCS_LOOP       2
`define QSL_TXCS_BRK        0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define QSL_BAUD_DIV_RST    16'h65ba
`define QSL_BREK_BITS       20'h0000b
`define QSL_FRAME_BITS      4'ha
`define QSL_DATA_LAST       3'h7
`define QSL_IRQ_PRIORITY    3'h4
`define QSL_RESP_OKAY       2'h0
`define QSL_RESP_SLVERR     2'h2

`endif

// [testbench/qsl_props.sv]
// Concurrent checks on the ports of the quad serial line unit.
// Assumes binding into qsl_top; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module qsl_props #(
  parameter UNITS    = 4,
  parameter ADDR_W   = 8,
  parameter BAUD_DIV = 8
) (
  input wire              aclk,
  input wire              aresetn,
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire              s_axi_wvalid,
  input wire              s_axi_wready,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire [31:0]       s_axi_rdata,
  input wire              s_axi_rvalid,
  input wire              s_axi_rready,
  input wire [UNITS-1:0]  txd,
  input wire [UNITS-1:0]  tx_int_request,
  input wire [2:0]        irq_priority
);
  // Length of the current level on line 0, saturating
  reg [15:0] run_r;
  reg        prev_r;
  always @(posedge aclk) begin
    prev_r <= txd[0];
    if (!aresetn)
      run_r <= 16'h0000;
    else if (txd[0] != prev_r)
      run_r <= 16'h0001;
    else if (run_r != 16'hffff)
      run_r <= run_r + 16'h0001;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_prio_fixed: assert property (irq_priority == 3'h4)
    else $error("interrupt priority not four");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read response dropped or changed");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_bit_length: assert property ((txd[0] != prev_r) && (run_r != 16'h0000)
    |-> run_r >= BAUD_DIV)
    else $error("serial bit shorter than one period");
  a_ready_idle: assert property ($rose(tx_int_request[0])
    |-> txd[0] && (run_r + 1 >= BAUD_DIV))
    else $error("transmit request before stop bit ended");
  a_reset_idle: assert property ($rose(aresetn) |-> &txd)
    else $error("serial output not idle after reset");
endmodule

// [testbench/qsl_far_end.sv]
// Remote serial terminal facing line 0: sends frames and decodes received ones.
// Assumes lines idle high and bit time of DIV clock cycles.
`timescale 1ns/10ps
module qsl_far_end #(
  parameter DIV = 8
) (
  input  wire       aclk,
  input  wire       line_in,
  output reg        line_out,
  output reg  [7:0] got_byte,
  output reg        got_stb
);
  integer i;
  initial begin
    line_out = 1'b1;
    got_byte = 8'h00;
    got_stb  = 1'b0;
  end

  // Gap after the stop bit sets how slowly the terminal talks
  task send(input [7:0] d, input stop_ok, input integer gap);
    integer j;
    begin
      line_out <= 1'b0;
      repeat (DIV) @(posedge aclk);
      for (j = 0; j < 8; j = j + 1) begin
        line_out <= d[j];
        repeat (DIV) @(posedge aclk);
      end
      line_out <= stop_ok;
      repeat (DIV) @(posedge aclk);
      line_out <= 1'b1;
      repeat (DIV * gap) @(posedge aclk);
    end
  endtask

  // A frame without a high stop bit is not reported
  always begin
    @(negedge line_in);
    repeat (DIV / 2) @(posedge aclk);
    for (i = 0; i < 8; i = i + 1) begin
      repeat (DIV) @(posedge aclk);
      got_byte[i] = line_in;
    end
    repeat (DIV) @(posedge aclk);
    got_stb <= line_in;
    @(posedge aclk);
    got_stb <= 1'b0;
  end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the quad serial line unit over AXI4-Lite.
// Assumes line 0 faces the far-end model and lines 1-3 loop txd back to rxd.
`timescale 1ns/10ps
module testbench;
  localparam DIV = 8;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg         bus_init = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00;
  reg         s_axi_awvalid = 1'b0;
  wire        s_axi_awready;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg         s_axi_wvalid = 1'b0;
  wire        s_axi_wready;
  wire [1:0]  s_axi_bresp;
  wire        s_axi_bvalid;
  reg         s_axi_bready = 1'b0;
  reg  [7:0]  s_axi_araddr = 8'h00;
  reg         s_axi_arvalid = 1'b0;
  wire        s_axi_arready;
  wire [31:0] s_axi_rdata;
  wire [1:0]  s_axi_rresp;
  wire        s_axi_rvalid;
  reg         s_axi_rready = 1'b0;
  wire [3:0]  rxd, txd, rx_int_request, tx_int_request;
  wire        irq, irq_grant_valid, far_line, far_stb;
  wire [2:0]  irq_priority, irq_grant_id;
  wire [7:0]  far_byte;
  integer     n_fail = 0;
  integer     n_checks = 0;
  reg  [65:0] rq[$];
  reg  [7:0]  sq[$];
  reg  [65:0] e;
  reg  [31:0] seed = 32'h904b;
  reg  [7:0]  b;
  integer     k;

  initial forever #2 aclk = ~aclk;
  assign rxd = {txd[3:1], far_line};
  qsl_top #(.BAUD_DIV(DIV)) u_qsl_top (.*);
  qsl_far_end #(.DIV(DIV)) u_qsl_far_end (.aclk(aclk), .line_in(txd[0]),
    .line_out(far_line), .got_byte(far_byte), .got_stb(far_stb));

  // ----
  // Tasks
  // ----
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      if (n_fail == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  function [31:0] lfsr(input [31:0] s);
    begin
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    end
  endfunction
  task rnd;
    begin
      seed = lfsr(seed);
      b = seed[7:0] | 8'h01;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] r = 2'h0);
    reg ta, tw, ha, hw;
    begin
      rq.push_back({r, 64'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
        @(negedge aclk);
        ha = s_axi_awvalid & s_axi_awready;
        hw = s_axi_wvalid & s_axi_wready;
        @(posedge aclk);
        if (ha) s_axi_awvalid <= 1'b0;
        if (hw) s_axi_wvalid <= 1'b0;
        ta = ta | ha;
        tw = tw | hw;
      end
      ha = 1'b0;
      while (!ha) begin
        @(negedge aclk);
        ha = s_axi_bvalid;
        @(posedge aclk);
      end
      // Late ready lets the response-hold checks see a waiting answer
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task rd(input [7:0] a, input [31:0] x, input [31:0] m, input [1:0] r = 2'h0);
    reg h;
    begin
      rq.push_back({r, m, x});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      h = 1'b0;
      while (!h) begin
        @(negedge aclk);
        h = s_axi_arready;
        @(posedge aclk);
      end
      s_axi_arvalid <= 1'b0;
      h = 1'b0;
      while (!h) begin
        @(negedge aclk);
        h = s_axi_rvalid;
        @(posedge aclk);
      end
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
    end
  endtask

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      e = rq.pop_front();
      chk(s_axi_bresp, e[65:64]);
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      chk(s_axi_rdata & e[63:32], e[31:0]);
      chk(s_axi_rresp, e[65:64]);
    end
    if (far_stb) chk(far_byte, sq.pop_front());
  end

  initial begin
    repeat (30000) @(posedge aclk);
    n_fail = n_fail + 1;
    final_report;
  end

  // ----
  // Scenarios
  // ----
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < 4; k = k + 1) begin
      rd({k[1:0], 4'h0}, 32'h0, 32'hffffffff);
      rd({k[1:0], 4'h4}, 32'h0, 32'hffffffff);
      rd({k[1:0], 4'h8}, 32'h80, 32'hffffffff);
      rd({k[1:0], 4'hc}, 32'h0, 32'hffffffff);
    end
    rd(8'h40, DIV, 32'hffff);
    wr(8'h40, DIV);
    wr(8'h50, 32'h0, 2'h2);
    rd(8'h50, 32'h0, 32'hffffffff, 2'h2);
    wr(8'h08, 32'h40);
    chk(tx_int_request, 4'h1);
    rnd;
    sq.push_back(b);
    wr(8'h0c, {24'hffffff, b});
    rd(8'h08, 32'h40, 32'hff);
    rd(8'h0c, {24'h0, b}, 32'hffffffff);
    while (!tx_int_request[0]) @(posedge aclk);
    rd(8'h08, 32'hc0, 32'hff);
    wr(8'h00, 32'h40);
    rnd;
    fork
      u_qsl_far_end.send(b, 1'b1, 1);
      begin
        repeat (3 * DIV) @(posedge aclk);
        rd(8'h00, 32'h840, 32'hfff);
      end
    join
    chk(rx_int_request, 4'h1);
    rd(8'h04, {24'h0, b}, 32'hffffffff);
    rd(8'h00, 32'h40, 32'hffffffff);
    rnd;
    u_qsl_far_end.send(b, 1'b1, 1);
    rnd;
    u_qsl_far_end.send(b, 1'b1, 1);
    rd(8'h04, {16'h0, 8'hc0, b}, 32'hffffffff);
    rnd;
    u_qsl_far_end.send(b, 1'b0, 2);
    rd(8'h04, {16'h0, 8'ha0, b}, 32'hf7ff);
    rnd;
    u_qsl_far_end.send(b, 1'b1, 1);
    rd(8'h04, {24'h0, b}, 32'hffffffff);
    wr(8'h08, 32'h04);
    rd(8'h08, 32'h84, 32'hc7);
    rnd;
    sq.push_back(b);
    wr(8'h0c, {24'h0, b});
    u_qsl_far_end.send(~b, 1'b1, 2);
    rd(8'h04, {24'h0, b}, 32'hffffffff);
    wr(8'h08, 32'h0);
    wr(8'h18, 32'h41);
    repeat (13 * DIV) @(posedge aclk);
    chk(txd[1], 32'h0);
    rd(8'h14, 32'h800, 32'h800);
    bus_init <= 1'b1;
    @(posedge aclk);
    bus_init <= 1'b0;
    rd(8'h18, 32'h80, 32'hff);
    rd(8'h00, 32'h0, 32'h40);
    rd(8'h14, 32'h0, 32'h800);
    // Line 1 may still finish a frame begun during break
    repeat (12 * DIV) @(posedge aclk);
    wr(8'h44, 32'hff);
    wr(8'h48, 32'hff);
    wr(8'h20, 32'h40);
    wr(8'h28, 32'h40);
    wr(8'h38, 32'h40);
    rnd;
    wr(8'h3c, {24'h0, b});
    wr(8'h2c, {24'h0, b});
    while (tx_int_request[3:2] != 2'b11) @(posedge aclk);
    repeat (4) @(posedge aclk);
    chk(irq, 32'h1);
    rd(8'h44, 32'hcc, 32'hff);
    rd(8'h4c, 32'ha, 32'hf);
    chk({irq_grant_valid, irq_grant_id}, 32'ha);
    wr(8'h48, 32'h0);
    chk(irq, 32'h0);
    wr(8'h48, 32'hff);
    wr(8'h44, 32'hff);
    chk(irq, 32'h0);
    repeat (2) @(posedge aclk);
    chk(rq.size() + sq.size(), 32'h0);
    final_report;
  end
endmodule

bind qsl_top qsl_props #(.UNITS(UNITS), .ADDR_W(ADDR_W), .BAUD_DIV(BAUD_DIV)) u_qsl_props (.*);
